// ===== hsc_channel.sv
// Purpose: One high-speed counter channel steered by its control code
// Assumes: Count and reset levels already synchronised to clock
// Notes: Elapsed value is a signed 24-bit count
`default_nettype none
module hsc_channel (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Control
	input wire hsc_pkg::code_t code,
	input wire logic resetAvail,
	input wire hsc_pkg::chanCmd_s cmd,
	// Synchronised pins
	input wire logic countIn,
	input wire logic resetIn,
	// Status
	output hsc_pkg::chanStat_s stat
);
	import hsc_pkg::*;

	typedef struct packed {
		chanStat_s st;
		logic [EV_W-1:0] target;
		logic setMode;
		logic cntPrev;
	} chanState_s;

	chanState_s state_r;
	chanState_s state_nxt;
	logic hwReset;
	logic countEdge;

	assign stat = state_r.st;

	always_comb begin
		state_nxt = state_r;
		state_nxt.cntPrev = countIn;
		// Reset input counts only when selected and not inhibited
		hwReset = resetIn && resetAvail && !code[BIT_HW_RST_INHIBIT]; // R5 R10 R11
		countEdge = countIn && !state_r.cntPrev;
		if (code[BIT_SW_RESET] || hwReset) begin
			state_nxt.st.elapsed = EV_ZERO; // R3 R16
		end else if (countEdge && !code[BIT_CNT_INHIBIT]) begin
			state_nxt.st.elapsed = cmd.upDown ? state_r.st.elapsed + EV_ONE
				: state_r.st.elapsed - EV_ONE; // R4
		end
		if (code[BIT_CLEAR_OPS]) begin
			// Elapsed value deliberately left alone here
			state_nxt.st.compareFlag = 1'b0; // R6 R7
			state_nxt.st.camFlag = 1'b0; // R7
			state_nxt.st.camOut = 1'b0; // R8
			state_nxt.st.patternOut = 1'b0; // R8
			state_nxt.st.pulseOut = 1'b0; // R12 R16
		end else begin
			if (state_r.st.compareFlag && state_r.st.elapsed == state_r.target) begin
				state_nxt.st.compareFlag = 1'b0;
				state_nxt.st.targetOut = state_r.setMode;
			end else if (cmd.targetLoad && !state_r.st.compareFlag) begin
				state_nxt.st.compareFlag = 1'b1;
				state_nxt.target = cmd.targetValue;
				state_nxt.setMode = cmd.targetSet;
			end
			if (cmd.camStart) begin
				state_nxt.st.camFlag = 1'b1;
				state_nxt.st.camOut = 1'b1;
			end
			if (cmd.spdStart) begin
				state_nxt.st.patternOut = 1'b1;
			end
			if (cmd.pulseStart && cmd.pulseMode) begin
				state_nxt.st.pulseOut = 1'b1;
			end
		end
		// Near-home is lost while counting is inhibited or held in reset
		state_nxt.st.nearHome = cmd.pulseMode && code[BIT_HW_RST_INHIBIT]
			&& !code[BIT_SW_RESET] && !code[BIT_CNT_INHIBIT]; // R13 R15
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end
endmodule
`default_nettype wire

// ===== hsc_control.sv
// Purpose: High-speed counter control word and its channels
// Assumes: Scan logic writes the whole control word in one cycle
// Notes: Upper byte out of range; such a write is refused and flagged
//
// Functional notes
// R1: Each channel owns its own four-bit field and acts on it alone.
// R2: A written code stays in force until the next write or until entry into run mode loads the low byte.
// R3: Bit 0 set forces the elapsed count to zero and holds it.
// R4: Bit 1 set ignores count pulses and holds the count.
// R5: Bit 2 set makes the external reset input ineffective.
// R6: Bit 3 clear runs compare, pattern and cam; set stops and clears them.
// R7: Bit 3 set drives compare and cam flags off, elapsed count untouched.
// R8: Bit 3 set switches off pattern and cam outputs.
// R9: Entering run mode loads zero into the control word low byte.
// R10: Reset input works only when selection setting is even, two to eight.
// R11: Reset inhibit only affects channels with a reset input.
// R12: In pulse control, bit 3 stops the pulse output.
// R13: In pulse control, bit 2 is the near-home input.
// R14: Software rewrites the near-home bit every scan.
// R15: Count inhibit or software reset suppresses near-home.
// R16: Code bits combine independently.
// R17: Out-of-range write sets a held error flag and a one-cycle pulse.
// R18: A new code acts on the cycle after its write, whole.
`default_nettype none
module hsc_control (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Control word access
	input wire logic ctrlWrite,
	input wire logic [hsc_pkg::WORD_W-1:0] ctrlWriteData,
	output logic [hsc_pkg::WORD_W-1:0] counterControlWord,
	// Mode and configuration
	input wire logic runMode,
	input wire logic [3:0] resetSelect,
	input wire logic errorClear,
	// Pins
	input wire logic [hsc_pkg::NUM_CH-1:0] countIn,
	input wire logic resetInputChA,
	input wire logic resetInputChB,
	// Channel requests and status
	input wire hsc_pkg::chanCmd_s [hsc_pkg::NUM_CH-1:0] chanCmd,
	output hsc_pkg::chanStat_s [hsc_pkg::NUM_CH-1:0] chanStat,
	// Error flags
	output logic operandErrorHoldFlag,
	output logic operandErrorPulseFlag
);
	import hsc_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [WORD_W-1:0] ctrlWord;
		logic runPrev;
		logic errHold;
		logic errPulse;
		logic [NUM_CH-1:0] cntMeta;
		logic [NUM_CH-1:0] cntSync;
		logic [NUM_CH-1:0] rstMeta;
		logic [NUM_CH-1:0] rstSync;
	} ctrlState_s;

	ctrlState_s state_r;
	ctrlState_s state_nxt;
	logic badWrite;
	logic runEdge;
	logic resetAvail;

	assign counterControlWord = state_r.ctrlWord;
	assign operandErrorHoldFlag = state_r.errHold;
	assign operandErrorPulseFlag = state_r.errPulse;
	assign resetAvail = resetSelected(resetSelect); // R10

	always_comb begin
		state_nxt = state_r;
		// Two-stage synchronisers for the pins
		state_nxt.cntMeta = countIn;
		state_nxt.cntSync = state_r.cntMeta;
		state_nxt.rstMeta = {resetInputChB, resetInputChA};
		state_nxt.rstSync = state_r.rstMeta;
		state_nxt.runPrev = runMode;
		badWrite = ctrlWrite && ((ctrlWriteData & RANGE_MASK) != '0);
		runEdge = runMode && !state_r.runPrev;
		if (ctrlWrite && !badWrite) begin
			state_nxt.ctrlWord = ctrlWriteData; // R2 R18
		end
		// Mode change wins over a write in the same cycle
		if (runEdge) begin
			state_nxt.ctrlWord[7:0] = RUN_LOW_BYTE; // R9
		end
		state_nxt.errPulse = badWrite; // R17
		// Set wins over clear
		if (badWrite) begin
			state_nxt.errHold = 1'b1; // R17
		end else if (errorClear) begin
			state_nxt.errHold = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Channels
	// ****************************************
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
		hsc_channel u_chan (
			.clock(clock),
			.reset(reset),
			.code(chanCode(state_r.ctrlWord, ch)), // R1 R16
			.resetAvail(resetAvail),
			.cmd(chanCmd[ch]),
			.countIn(state_r.cntSync[ch]),
			.resetIn(state_r.rstSync[ch]),
			.stat(chanStat[ch])
		);
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence goodWriteSeq;
		ctrlWrite && ((ctrlWriteData & RANGE_MASK) == '0) && !(runMode && !state_r.runPrev);
	endsequence

	sequence swResetSeq;
		goodWriteSeq ##0 ctrlWriteData[BIT_SW_RESET];
	endsequence

	chk_field_isolation: assert property (goodWriteSeq ##0 (ctrlWriteData[7:4] == state_r.ctrlWord[7:4])
		|=> $stable(state_r.ctrlWord[7:4])) else $error("channel field changed"); // R1
	chk_code_holds: assert property (!ctrlWrite && !(runMode && !state_r.runPrev)
		|=> $stable(state_r.ctrlWord)) else $error("code changed without write"); // R2
	chk_sw_reset_zero: assert property (swResetSeq |-> ##2 chanStat[0].elapsed == EV_ZERO)
		else $error("software reset did not zero count"); // R3 R18
	chk_inhibit_holds: assert property (state_r.ctrlWord[3:0] == 4'h6 ##1 state_r.ctrlWord[3:0] == 4'h6
		|=> $stable(chanStat[0].elapsed)) else $error("count moved while inhibited"); // R4 R5
	chk_clear_ops: assert property (state_r.ctrlWord[BIT_CLEAR_OPS]
		|=> !chanStat[0].compareFlag && !chanStat[0].camFlag && !chanStat[0].camOut
		&& !chanStat[0].patternOut) else $error("ops not cleared"); // R6 R7 R8
	chk_clear_keeps_ev: assert property (state_r.ctrlWord[3:0] == 4'ha ##1 state_r.ctrlWord[3:0] == 4'ha
		|=> $stable(chanStat[0].elapsed)) else $error("clear touched count"); // R7
	chk_pulse_stop: assert property (state_r.ctrlWord[BIT_CLEAR_OPS] |=> !chanStat[0].pulseOut)
		else $error("pulse output not stopped"); // R12
	chk_combined_nine: assert property (state_r.ctrlWord[3:0] == 4'h9
		|=> chanStat[0].elapsed == EV_ZERO && !chanStat[0].pulseOut)
		else $error("combined code failed"); // R16
	chk_near_home: assert property (##1 chanStat[0].nearHome == $past(chanCmd[0].pulseMode
		&& state_r.ctrlWord[2] && !state_r.ctrlWord[1] && !state_r.ctrlWord[0]))
		else $error("near-home wrong"); // R13 R15
	chk_run_entry: assert property (runMode && !state_r.runPrev
		|=> state_r.ctrlWord[7:0] == RUN_LOW_BYTE) else $error("low byte not cleared"); // R9
	chk_error_flags: assert property (ctrlWrite && ((ctrlWriteData & RANGE_MASK) != '0)
		|=> operandErrorPulseFlag && operandErrorHoldFlag && $stable(state_r.ctrlWord[15:8])
		##1 !operandErrorPulseFlag || $past(badWrite)) else $error("error flags wrong"); // R17

	// ****************************************
	// Error, channel 1 and operation checks
	// ****************************************
	// Refused writes must never leak into the word
	sequence badWriteSeq;
		ctrlWrite && ((ctrlWriteData & RANGE_MASK) != '0);
	endsequence

	sequence ch1SwResetSeq;
		goodWriteSeq ##0 ctrlWriteData[CODE_W + BIT_SW_RESET];
	endsequence

	// Loads are refused while a compare is pending
	sequence targetLoadSeq;
		chanCmd[0].targetLoad && !chanStat[0].compareFlag && !state_r.ctrlWord[BIT_CLEAR_OPS];
	endsequence

	chk_word_follows: assert property (goodWriteSeq // R2 R18
		|=> state_r.ctrlWord == $past(ctrlWriteData)) else $error("written word not taken");

	chk_refused_word: assert property (badWriteSeq ##0 !runEdge // R17
		|=> $stable(state_r.ctrlWord)) else $error("refused write changed word");

	chk_set_wins: assert property (badWriteSeq ##0 errorClear // R17
		|=> operandErrorHoldFlag) else $error("clear beat error set");

	chk_hold_clears: assert property (errorClear && !badWrite // R17
		|=> !operandErrorHoldFlag) else $error("held error not cleared");

	chk_hold_sticky: assert property (operandErrorHoldFlag && !errorClear // R17
		|=> operandErrorHoldFlag) else $error("held error dropped");

	chk_pulse_single: assert property (operandErrorPulseFlag // R17
		|-> $past(badWrite)) else $error("error pulse without bad write");

	chk_error_quiet: assert property (!badWrite // R17
		|=> !operandErrorPulseFlag) else $error("error pulse too long");

	// Second channel acts on its own field only
	chk_ch1_sw_reset: assert property (ch1SwResetSeq |-> ##2 chanStat[1].elapsed == EV_ZERO) // R1 R3
		else $error("channel 1 software reset failed");

	chk_ch1_inhibit: assert property (state_r.ctrlWord[7:4] == 4'h2 && !state_r.rstSync[1] // R1 R4
		|=> $stable(chanStat[1].elapsed)) else $error("channel 1 counted while inhibited");

	chk_sw_reset_hold: assert property (state_r.ctrlWord[BIT_SW_RESET] // R3
		|=> chanStat[0].elapsed == EV_ZERO) else $error("count not held at zero");

	// Pin reset lands one cycle after the second sync stage
	chk_reset_pin_zero: assert property (state_r.rstSync[0] && resetAvail && !state_r.ctrlWord[2] // R5 R10
		|=> chanStat[0].elapsed == EV_ZERO) else $error("reset pin ignored");

	chk_target_load: assert property (targetLoadSeq // R6
		|=> chanStat[0].compareFlag) else $error("target load not taken");

	chk_cam_runs: assert property (!state_r.ctrlWord[BIT_CLEAR_OPS] && chanCmd[0].camStart // R6
		|=> chanStat[0].camOut && chanStat[0].camFlag)
		else $error("cam operation not started");

	chk_pulse_runs: assert property (!state_r.ctrlWord[BIT_CLEAR_OPS] && chanCmd[0].pulseStart // R6 R12
		&& chanCmd[0].pulseMode |=> chanStat[0].pulseOut) else $error("pulse output not started");
endmodule
`default_nettype wire

// ===== hsc_pins_model.sv
// Purpose: Far-side model of the count and reset pins of both channels
// Assumes: Block samples pins through two sync stages
// Notes: Pulse high phases last three cycles, low phases three cycles
`default_nettype none
module hsc_pins_model (
	// Clock
	input wire logic clock,
	// Pins
	output logic [1:0] countIn,
	output logic resetInputChA,
	output logic resetInputChB
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		countIn = 2'h0;
		resetInputChA = 1'b0;
		resetInputChB = 1'b0;
	end
	// ************
	// Pin tasks
	// ************
	// Three-cycle high and three-cycle low phases clear the synchroniser's two-cycle minimum
	task pulse(input int ch, input int n);
		repeat (n) begin
			@(posedge clock);
			countIn[ch] <= 1'b1;
			repeat (3) @(posedge clock);
			countIn[ch] <= 1'b0;
			repeat (2) @(posedge clock);
		end
		repeat (5) @(posedge clock);
	endtask
	task pressReset(input int ch);
		@(posedge clock);
		if (ch == 0) resetInputChA <= 1'b1;
		else resetInputChB <= 1'b1;
		repeat (4) @(posedge clock);
		if (ch == 0) resetInputChA <= 1'b0;
		else resetInputChB <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// ===== hsc_pkg.sv
// Purpose: Shared constants and carriers for the high-speed counter control block
// Assumes: One scan clock; control word written one whole word at a time
// Notes: Two counter channels, four control bits each, in the low byte
`default_nettype none
package hsc_pkg;
	localparam int NUM_CH = 2;
	localparam int CODE_W = 4;
	localparam int WORD_W = 16;
	localparam int EV_W = 24;
	// Control code bit positions inside one channel field
	localparam int BIT_SW_RESET = 0;
	localparam int BIT_CNT_INHIBIT = 1;
	localparam int BIT_HW_RST_INHIBIT = 2;
	localparam int BIT_CLEAR_OPS = 3;
	// Control word layout and values
	localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [7:0] RUN_LOW_BYTE = 8'h00;
	localparam logic [WORD_W-1:0] RANGE_MASK = 16'hff00;
	// Reset input selection setting: even values in this range only
	localparam logic [3:0] RST_SEL_LO = 4'h2;
	localparam logic [3:0] RST_SEL_HI = 4'h8;
	localparam logic [EV_W-1:0] EV_ZERO = 24'h000000;
	localparam logic [EV_W-1:0] EV_ONE = 24'h000001;

	typedef logic [CODE_W-1:0] code_t;

	// Per-channel request group from the scan logic
	typedef struct packed {
		logic upDown;
		logic targetLoad;
		logic targetSet;
		logic [EV_W-1:0] targetValue;
		logic camStart;
		logic spdStart;
		logic pulseStart;
		logic pulseMode;
	} chanCmd_s;

	// Per-channel status
	typedef struct packed {
		logic [EV_W-1:0] elapsed;
		logic compareFlag;
		logic camFlag;
		logic targetOut;
		logic camOut;
		logic patternOut;
		logic pulseOut;
		logic nearHome;
	} chanStat_s;

	function automatic code_t chanCode(input logic [WORD_W-1:0] word, input int ch);
		chanCode = word[ch*CODE_W +: CODE_W];
	endfunction

	function automatic logic resetSelected(input logic [3:0] sel);
		resetSelected = !sel[0] && sel >= RST_SEL_LO && sel <= RST_SEL_HI;
	endfunction
endpackage
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for the counter control block
// Assumes: Control word written whole through the write strobe
// Notes: Expected counts follow from the pulses the pin model makes
`default_nettype none
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hsc_pkg::*;
	logic clock, reset, ctrlWrite, runMode, errorClear, resetInputChA, resetInputChB;
	logic [15:0] ctrlWriteData, counterControlWord;
	logic [3:0] resetSelect;
	logic [1:0] countIn;
	chanCmd_s [1:0] chanCmd;
	chanStat_s [1:0] chanStat;
	logic operandErrorHoldFlag, operandErrorPulseFlag;
	int errors = 0;
	int checks = 0;
	hsc_control u_hsc_control (.clock(clock), .reset(reset), .ctrlWrite(ctrlWrite),
		.ctrlWriteData(ctrlWriteData), .counterControlWord(counterControlWord),
		.runMode(runMode), .resetSelect(resetSelect), .errorClear(errorClear),
		.countIn(countIn), .resetInputChA(resetInputChA), .resetInputChB(resetInputChB),
		.chanCmd(chanCmd), .chanStat(chanStat), .operandErrorHoldFlag(operandErrorHoldFlag),
		.operandErrorPulseFlag(operandErrorPulseFlag));
	hsc_pins_model u_hsc_pins_model (.clock(clock), .countIn(countIn),
		.resetInputChA(resetInputChA), .resetInputChB(resetInputChB));
	// ************
	// Tasks
	// ************
	task automatic wr(input logic [15:0] d);
		@(posedge clock);
		ctrlWrite <= 1'b1;
		ctrlWriteData <= d;
		@(posedge clock);
		ctrlWrite <= 1'b0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic stop_test();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		repeat (6000) @(posedge clock);
		errors++;
		stop_test();
	end
	// ************
	// Tests
	// ************
	initial begin
		{reset, ctrlWrite, runMode, errorClear} = 4'h8;
		ctrlWriteData = 16'h0000;
		resetSelect = 4'h0;
		chanCmd = '0;
		chanCmd[0].upDown = 1'b1;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		cyc(1);
		`CHECK(counterControlWord, 16'h0000)
		`CHECK(operandErrorHoldFlag, 1'b0)
		@(posedge clock);
		u_hsc_pins_model.pulse(0, 3);
		u_hsc_pins_model.pulse(1, 2);
		`CHECK(chanStat[0].elapsed, 24'h000003)
		`CHECK(chanStat[1].elapsed, 24'hfffffe)
		wr(16'h0020);
		u_hsc_pins_model.pulse(0, 1);
		u_hsc_pins_model.pulse(1, 1);
		`CHECK(chanStat[0].elapsed, 24'h000004)
		`CHECK(chanStat[1].elapsed, 24'hfffffe)
		wr(16'h0001);
		u_hsc_pins_model.pulse(0, 2);
		`CHECK(chanStat[0].elapsed, 24'h000000)
		`CHECK(counterControlWord, 16'h0001)
		wr(16'h0000);
		u_hsc_pins_model.pulse(0, 2);
		`CHECK(chanStat[0].elapsed, 24'h000002)
		@(posedge clock);
		resetSelect <= 4'h4;
		u_hsc_pins_model.pressReset(0);
		`CHECK(chanStat[0].elapsed, 24'h000000)
		u_hsc_pins_model.pulse(0, 1);
		wr(16'h0004);
		u_hsc_pins_model.pressReset(0);
		`CHECK(chanStat[0].elapsed, 24'h000001)
		wr(16'h0000);
		resetSelect <= 4'h3;
		u_hsc_pins_model.pressReset(0);
		`CHECK(chanStat[0].elapsed, 24'h000001)
		@(posedge clock);
		chanCmd[0].targetValue <= 24'h000100;
		chanCmd[0].targetLoad <= 1'b1;
		@(posedge clock);
		chanCmd[0].targetLoad <= 1'b0;
		cyc(1);
		`CHECK(chanStat[0].compareFlag, 1'b1)
		@(posedge clock);
		chanCmd[0].pulseMode <= 1'b1;
		chanCmd[0].camStart <= 1'b1;
		chanCmd[0].spdStart <= 1'b1;
		chanCmd[0].pulseStart <= 1'b1;
		@(posedge clock);
		{chanCmd[0].camStart, chanCmd[0].spdStart, chanCmd[0].pulseStart} <= 3'h0;
		cyc(1);
		`CHECK(chanStat[0].camOut, 1'b1)
		`CHECK(chanStat[0].camFlag, 1'b1)
		`CHECK(chanStat[0].patternOut, 1'b1)
		`CHECK(chanStat[0].pulseOut, 1'b1)
		wr(16'h000a);
		@(posedge clock);
		{chanCmd[0].camStart, chanCmd[0].spdStart, chanCmd[0].pulseStart} <= 3'h7;
		@(posedge clock);
		{chanCmd[0].camStart, chanCmd[0].spdStart, chanCmd[0].pulseStart} <= 3'h0;
		cyc(2);
		`CHECK(chanStat[0].compareFlag, 1'b0)
		`CHECK(chanStat[0].camFlag, 1'b0)
		`CHECK(chanStat[0].elapsed, 24'h000001)
		`CHECK(chanStat[0].patternOut, 1'b0)
		`CHECK(chanStat[0].pulseOut, 1'b0)
		wr(16'h0009);
		cyc(2);
		`CHECK(chanStat[0].elapsed, 24'h000000)
		`CHECK(chanStat[0].pulseOut, 1'b0)
		chanCmd[0].pulseMode <= 1'b1;
		repeat (3) wr(16'h0004);
		cyc(2);
		`CHECK(chanStat[0].nearHome, 1'b1)
		wr(16'h0006);
		cyc(2);
		`CHECK(chanStat[0].nearHome, 1'b0)
		wr(16'h0005);
		cyc(2);
		`CHECK(chanStat[0].nearHome, 1'b0)
		@(posedge clock);
		errorClear <= 1'b1;
		wr(16'h0100);
		errorClear <= 1'b0;
		#1;
		`CHECK(operandErrorPulseFlag, 1'b1)
		cyc(1);
		`CHECK(operandErrorPulseFlag, 1'b0)
		`CHECK(operandErrorHoldFlag, 1'b1)
		`CHECK(counterControlWord, 16'h0005)
		@(posedge clock);
		errorClear <= 1'b1;
		@(posedge clock);
		errorClear <= 1'b0;
		cyc(1);
		`CHECK(operandErrorHoldFlag, 1'b0)
		wr(16'h0000);
		@(posedge clock);
		chanCmd[0].targetValue <= 24'h000001;
		chanCmd[0].targetSet <= 1'b1;
		chanCmd[0].targetLoad <= 1'b1;
		@(posedge clock);
		chanCmd[0].targetLoad <= 1'b0;
		u_hsc_pins_model.pulse(0, 1);
		`CHECK(chanStat[0].targetOut, 1'b1)
		`CHECK(chanStat[0].compareFlag, 1'b0)
		wr(16'h00ff);
		runMode <= 1'b1;
		cyc(2);
		`CHECK(counterControlWord, 16'h0000)
		stop_test();
	end
endmodule
`default_nettype wire
